/* src/ufr_pkg.sv */
// Shared constants, register map and state record of the serial port core.
// Assumes one clock domain on mclk at 100 MHz and a byte-wide host register port.
package ufr_pkg;
  // ==========================================================================
  // Clocking and baud reference
  localparam int unsigned CLK_HZ = 32'h05F5_E100;
  // 7.3728 MHz reference, so divisor 1 gives the fastest line rate
  localparam int unsigned REF_HZ = 32'h0070_8000;
  localparam logic [31:0] NCO_INC = 32'((64'(REF_HZ) << 32) / 64'(CLK_HZ));
  localparam logic [4:0] BIT_LAST = 5'h0F;
  localparam logic [4:0] HALF_LAST = 5'h07;
  localparam logic [4:0] STOP15_LAST = 5'h17;
  localparam logic [4:0] STOP2_LAST = 5'h1F;
  localparam logic [9:0] TOUT_TICKS = 10'h280;
  // ==========================================================================
  // Register offsets
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_IIR = 3'h2;
  localparam logic [2:0] OFS_LCR = 3'h3;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;
  // ==========================================================================
  // Field positions and codes
  localparam int LCR_DLS = 7;
  localparam int LCR_BRK = 6;
  localparam int LCR_STICK = 5;
  localparam int LCR_EVEN = 4;
  localparam int LCR_PEN = 3;
  localparam int LCR_STOP = 2;
  localparam int MCR_GATE = 3;
  localparam int FCR_EN = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  localparam int FCR_TRIG = 6;
  localparam logic [7:0] FCR_SELFCLR = 8'hF9;
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LINE = 4'h6;
  localparam logic [3:0] IIR_RDA = 4'h4;
  localparam logic [3:0] IIR_TOUT = 4'hC;
  localparam logic [3:0] IIR_THRE = 4'h2;
  localparam logic [3:0] IIR_MODEM = 4'h0;
  localparam int TRIG_L0 = 1;
  localparam int TRIG_L1 = 4;
  localparam int TRIG_L2 = 8;
  localparam int TRIG_L3 = 14;
  // ==========================================================================
  // Types
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufr_rx_e;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufr_tx_e;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ufr_bus_req_s;
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [3:0] interrupt_enable;
    logic [7:0] lcr;
    logic [4:0] mcr;
    logic [7:0] scr;
    logic [15:0] div;
    logic fifo_en;
    logic [1:0] trig;
    logic [7:0] shadow;
    logic [31:0] nco;
    logic [15:0] bcnt;
    logic tick;
    logic [3:0] err;
    logic thre_int;
    logic tx_empty_prev;
    logic [3:0] msr_delta;
    logic [3:0] msr_lvl;
    ufr_rx_e rx_st;
    logic [4:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_perr;
    logic rx_push;
    logic [7:0] rx_word;
    ufr_tx_e tx_st;
    logic [4:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_space;
    logic [9:0] tout_cnt;
    logic tout;
    logic [7:0] rdata;
  } ufr_state_s;
endpackage

/* src/ufr_core.sv */
// Serial port core: host registers, baud generator, framer, deframer and FIFOs.
// Assumes host strobes are synchronous to mclk; serial and modem pins are not.
// Contract
// - Address by low three bits plus divisor select
// - Bit rate from 16-bit divisor 1..65535
// - Line rates from 460.8K down to about 7 baud
// - One start, 1/1.5/2 stop, selectable parity
// - Interrupt passes only while output gate set
// - Characters shift least significant bit first
// - Receive shifts hidden, then moves to holding
// - Transmit shifter loads only after previous done
// - All enables clear suppresses identification and interrupt
// - Enable bit0 allows data and timeout
// - Enable bit1 allows transmit-empty interrupt
// - Enable bit2 allows line status interrupt
// - Enable bit3 allows modem change interrupt
// - Upper four enable bits read zero
// - FIFO control write-only, mirrored to shadow
// - Control bit0 enables or disables/clears FIFOs
// - Bit1 flushes receive FIFO, self-clears
// - Bit2 flushes transmit FIFO, self-clears
// - Bit3 accepted without effect
// - Bits 7:6 pick receive trigger level
`timescale 1ns/1ps

// ============================================================================
// FIFO
module ufr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic flush,
  input wire logic single,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [CW-1:0] cnt;
  } ufr_fifo_state_s;
  ufr_fifo_state_s st_q, st_d;
  logic push, pop;

  // Single mode caps the store at one word, as a plain holding register
  assign in_ready = single ? (st_q.cnt == '0) : (st_q.cnt != CW'(DEPTH));
  assign out_valid = st_q.cnt != '0;
  assign out_data = st_q.mem[st_q.rd];
  assign count = st_q.cnt;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    st_d = st_q;
    if (flush) begin
      st_d.rd = '0;
      st_d.wr = '0;
      st_d.cnt = '0;
    end else begin
      if (push) begin
        st_d.mem[st_q.wr] = in_data;
        st_d.wr = (st_q.wr == AW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
      end
      if (pop) begin
        st_d.rd = (st_q.rd == AW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
      end
      st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end
endmodule

// ============================================================================
// Port core
module ufr_core import ufr_pkg::*; #(
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 8,
  localparam int RCW = $clog2(RX_DEPTH + 1),
  localparam int TCW = $clog2(TX_DEPTH + 1)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire ufr_bus_req_s bus,
  output logic [7:0] rdata,
  input wire logic rxd,
  input wire logic [3:0] modem_in_n,
  output logic txd,
  output logic dtr_n,
  output logic rts_n,
  output logic aux_out_n,
  output logic gate_out_n,
  output logic irq,
  output logic [7:0] fifo_control_shadow
);
  ufr_state_s q, d;
  logic [32:0] nco_sum;
  logic dls, rx_line, tx_empty, rda_lvl;
  logic rx_pop, rx_flush, tx_push, tx_pop, tx_flush, rx_in_ready, rx_out_valid, tx_out_valid;
  logic [7:0] rx_out_data, tx_out_data, rx_data, wmask;
  logic [RCW-1:0] rx_count;
  logic [TCW-1:0] tx_count;
  logic [3:0] iir_code;
  logic [2:0] last_bit;
  logic [4:0] stop_last;
  int trig_level;

  function automatic logic par_bit(input logic [7:0] data, input logic [7:0] lcr);
    return lcr[LCR_STICK] ? ~lcr[LCR_EVEN] : (^data ^ ~lcr[LCR_EVEN]);
  endfunction

  ufr_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .mclk(mclk), .reset(reset), .ce(ce), .flush(rx_flush), .single(~q.fifo_en),
    .in_valid(q.rx_push), .in_ready(rx_in_ready), .in_data(q.rx_word),
    .out_valid(rx_out_valid), .out_ready(rx_pop), .out_data(rx_out_data), .count(rx_count));
  ufr_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .mclk(mclk), .reset(reset), .ce(ce), .flush(tx_flush), .single(~q.fifo_en),
    .in_valid(tx_push), .in_ready(), .in_data(bus.wdata),
    .out_valid(tx_out_valid), .out_ready(tx_pop), .out_data(tx_out_data), .count(tx_count));

  // ==========================================================================
  // Derived terms
  assign dls = q.lcr[LCR_DLS];
  assign rx_line = ~q.sync2[0];
  assign tx_empty = tx_count == '0;
  assign wmask = 8'hFF >> (2'h3 - q.lcr[1:0]);
  assign rx_data = q.rx_sh >> (2'h3 - q.lcr[1:0]);
  assign last_bit = {1'b1, q.lcr[1:0]};
  assign nco_sum = {1'b0, q.nco} + {1'b0, NCO_INC};
  always_comb begin
    stop_last = BIT_LAST;
    if (q.lcr[LCR_STOP]) begin
      stop_last = (q.lcr[1:0] == 2'h0) ? STOP15_LAST : STOP2_LAST;
    end
    case (q.trig)
      2'h0: trig_level = TRIG_L0;
      2'h1: trig_level = TRIG_L1;
      2'h2: trig_level = TRIG_L2;
      default: trig_level = TRIG_L3;
    endcase
    rda_lvl = q.fifo_en ? (int'(rx_count) >= trig_level) : rx_out_valid;
    // Each source is gated by its own enable, so a zero enable field reads as none
    if (q.interrupt_enable[2] && q.err != 4'h0) begin
      iir_code = IIR_LINE;
    end else if (q.interrupt_enable[0] && rda_lvl) begin
      iir_code = IIR_RDA;
    end else if (q.interrupt_enable[0] && q.fifo_en && q.tout) begin
      iir_code = IIR_TOUT;
    end else if (q.interrupt_enable[1] && q.thre_int) begin
      iir_code = IIR_THRE;
    end else if (q.interrupt_enable[3] && q.msr_delta != 4'h0) begin
      iir_code = IIR_MODEM;
    end else begin
      iir_code = IIR_NONE;
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    rx_pop = 1'b0;
    rx_flush = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    tx_flush = 1'b0;
    d.tick = 1'b0;
    d.rx_push = 1'b0;
    // Inverted ahead of the first stage so reset reads as an idle line
    d.sync1 = {~modem_in_n, ~rxd};
    d.sync2 = q.sync1;
    d.nco = nco_sum[31:0];
    if (nco_sum[32] && q.div != 16'h0000) begin
      if (q.bcnt >= q.div - 16'h0001) begin
        d.bcnt = 16'h0000;
        d.tick = 1'b1;
      end else begin
        d.bcnt = q.bcnt + 16'h0001;
      end
    end
    // Host reads; clears placed before the sets below so a set wins
    if (bus.rd) begin
      if (bus.addr == OFS_DATA) begin
        d.rdata = dls ? q.div[7:0] : rx_out_data;
        rx_pop = ~dls;
      end else if (bus.addr == OFS_IER) begin
        d.rdata = dls ? q.div[15:8] : {4'h0, q.interrupt_enable};
      end else if (bus.addr == OFS_IIR) begin
        d.rdata = {q.fifo_en, q.fifo_en, 2'h0, iir_code};
        if (iir_code == IIR_THRE) begin
          d.thre_int = 1'b0;
        end
      end else if (bus.addr == OFS_LCR) begin
        d.rdata = q.lcr;
      end else if (bus.addr == OFS_MCR) begin
        d.rdata = {3'h0, q.mcr};
      end else if (bus.addr == OFS_LSR) begin
        d.rdata = {1'b0, tx_empty & (q.tx_st == TX_IDLE), tx_empty, q.err, rx_out_valid};
        d.err = 4'h0;
      end else if (bus.addr == OFS_MSR) begin
        d.rdata = {q.msr_lvl, q.msr_delta};
        d.msr_delta = 4'h0;
      end else begin
        d.rdata = q.scr;
      end
    end
    // Host writes
    if (bus.wr) begin
      if (bus.addr == OFS_DATA) begin
        if (dls) begin
          d.div[7:0] = bus.wdata;
        end else begin
          tx_push = 1'b1;
          d.thre_int = 1'b0;
        end
      end else if (bus.addr == OFS_IER) begin
        if (dls) begin
          d.div[15:8] = bus.wdata;
        end else begin
          d.interrupt_enable = bus.wdata[3:0];
        end
      end else if (bus.addr == OFS_IIR) begin
        d.shadow = bus.wdata & FCR_SELFCLR;
        // Bit 3 selects a transfer mode with no pins behind it, so it only reaches the shadow
        if (bus.wdata[FCR_EN]) begin
          d.fifo_en = 1'b1;
          d.trig = bus.wdata[FCR_TRIG +: 2];
          rx_flush = bus.wdata[FCR_RXCLR] | ~q.fifo_en;
          tx_flush = bus.wdata[FCR_TXCLR] | ~q.fifo_en;
        end else begin
          d.fifo_en = 1'b0;
          rx_flush = 1'b1;
          tx_flush = 1'b1;
        end
      end else if (bus.addr == OFS_LCR) begin
        d.lcr = bus.wdata;
      end else if (bus.addr == OFS_MCR) begin
        d.mcr = bus.wdata[4:0];
      end else if (bus.addr == OFS_SCR) begin
        d.scr = bus.wdata;
      end
      if (bus.addr == OFS_IER && !dls && bus.wdata[1] && !q.interrupt_enable[1] && tx_empty) begin
        d.thre_int = 1'b1;
      end
    end
    // Status events
    d.tx_empty_prev = tx_empty;
    if (tx_empty && !q.tx_empty_prev) begin
      d.thre_int = 1'b1;
    end
    d.msr_lvl = q.sync2[4:1];
    d.msr_delta = d.msr_delta | {q.msr_lvl[3] ^ q.sync2[4], q.msr_lvl[2] & ~q.sync2[3],
                                 q.msr_lvl[1] ^ q.sync2[2], q.msr_lvl[0] ^ q.sync2[1]};
    if (q.rx_push && !rx_in_ready) begin
      d.err[0] = 1'b1;
    end
    // Receiver, sampled at sixteen ticks per bit
    if (q.tick) begin
      d.rx_cnt = q.rx_cnt + 5'h01;
      case (q.rx_st)
        RX_IDLE: begin
          d.rx_cnt = 5'h00;
          if (!rx_line) begin
            d.rx_st = RX_START;
          end
        end
        RX_START: begin
          if (q.rx_cnt == HALF_LAST) begin
            d.rx_cnt = 5'h00;
            d.rx_bit = 3'h0;
            d.rx_perr = 1'b0;
            d.rx_st = rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (q.rx_cnt == BIT_LAST) begin
            d.rx_cnt = 5'h00;
            d.rx_sh = {rx_line, q.rx_sh[7:1]};
            d.rx_bit = q.rx_bit + 3'h1;
            if (q.rx_bit == last_bit) begin
              d.rx_st = q.lcr[LCR_PEN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (q.rx_cnt == BIT_LAST) begin
            d.rx_cnt = 5'h00;
            d.rx_perr = rx_line != par_bit(rx_data, q.lcr);
            d.rx_st = RX_STOP;
          end
        end
        default: begin
          // Only the first stop bit is checked
          if (q.rx_cnt == BIT_LAST) begin
            d.rx_push = 1'b1;
            d.rx_word = rx_data;
            // Built on the cleared copy so a same-cycle status read is not undone
            d.err[1] = d.err[1] | q.rx_perr;
            d.err[2] = d.err[2] | ~rx_line;
            d.err[3] = d.err[3] | (~rx_line & rx_data == 8'h00);
            d.rx_st = RX_IDLE;
          end
        end
      endcase
    end
    // Transmitter
    if (q.tx_st == TX_IDLE) begin
      d.tx_cnt = 5'h00;
      if (tx_out_valid) begin
        tx_pop = 1'b1;
        d.tx_sh = tx_out_data & wmask;
        d.tx_par = par_bit(tx_out_data & wmask, q.lcr);
        d.tx_space = 1'b1;
        d.tx_st = TX_START;
      end
    end else if (q.tick) begin
      d.tx_cnt = q.tx_cnt + 5'h01;
      case (q.tx_st)
        TX_START: begin
          if (q.tx_cnt == BIT_LAST) begin
            d.tx_cnt = 5'h00;
            d.tx_bit = 3'h0;
            d.tx_space = ~q.tx_sh[0];
            d.tx_st = TX_DATA;
          end
        end
        TX_DATA: begin
          if (q.tx_cnt == BIT_LAST) begin
            d.tx_cnt = 5'h00;
            d.tx_sh = {1'b0, q.tx_sh[7:1]};
            d.tx_space = ~q.tx_sh[1];
            d.tx_bit = q.tx_bit + 3'h1;
            if (q.tx_bit == last_bit) begin
              d.tx_space = q.lcr[LCR_PEN] ? ~q.tx_par : 1'b0;
              d.tx_st = q.lcr[LCR_PEN] ? TX_PAR : TX_STOP;
            end
          end
        end
        TX_PAR: begin
          if (q.tx_cnt == BIT_LAST) begin
            d.tx_cnt = 5'h00;
            d.tx_space = 1'b0;
            d.tx_st = TX_STOP;
          end
        end
        default: begin
          if (q.tx_cnt == stop_last) begin
            d.tx_st = TX_IDLE;
          end
        end
      endcase
    end
    // Character timeout, roughly four characters with no FIFO activity
    if (!q.fifo_en || !rx_out_valid || q.rx_push || rx_pop) begin
      d.tout_cnt = 10'h000;
      d.tout = 1'b0;
    end else if (q.tick && q.tout_cnt != TOUT_TICKS) begin
      d.tout_cnt = q.tout_cnt + 10'h001;
      d.tout = d.tout_cnt == TOUT_TICKS;
    end
  end

  // Reset leaves enables clear and both FIFOs off and empty
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdata = q.rdata;
  assign txd = ~(q.tx_space | q.lcr[LCR_BRK]);
  assign dtr_n = ~q.mcr[0];
  assign rts_n = ~q.mcr[1];
  assign aux_out_n = ~q.mcr[2];
  assign gate_out_n = ~q.mcr[MCR_GATE];
  assign irq = (iir_code != IIR_NONE) & q.mcr[MCR_GATE];
  assign fifo_control_shadow = q.shadow;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset || !ce);

  sequence s_fcr_wr;
    bus.wr && bus.addr == OFS_IIR;
  endsequence
  sequence s_tx_begin;
    q.tx_st == TX_START ##1 q.tx_st == TX_DATA;
  endsequence

  AST_IER_UPPER_ZERO: assert property (bus.rd && bus.addr == OFS_IER && !dls |=> rdata[7:4] == 4'h0)
    else $error("upper enable bits read nonzero");
  AST_IRQ_GATED: assert property (!q.mcr[MCR_GATE] |-> !irq)
    else $error("interrupt passed with gate low");
  AST_IRQ_NO_ENABLE: assert property (q.interrupt_enable == 4'h0 |-> !irq && iir_code == IIR_NONE)
    else $error("interrupt with all enables clear");
  AST_DIV_WRITE: assert property (bus.wr && bus.addr == OFS_DATA && dls |=> q.div[7:0] == $past(bus.wdata))
    else $error("divisor low byte not written");
  AST_DIV_NO_TX: assert property (bus.wr && bus.addr == OFS_DATA && dls |-> !tx_push)
    else $error("divisor write reached transmit path");
  AST_FIFO_OFF: assert property (s_fcr_wr ##0 !bus.wdata[FCR_EN] |=> !q.fifo_en && rx_count == '0 && tx_count == '0)
    else $error("FIFOs not disabled and cleared");
  AST_RX_FLUSH: assert property (s_fcr_wr ##0 bus.wdata[FCR_EN] && bus.wdata[FCR_RXCLR] |=> rx_count == '0)
    else $error("receive FIFO not flushed");
  AST_TX_FLUSH: assert property (s_fcr_wr ##0 bus.wdata[FCR_EN] && bus.wdata[FCR_TXCLR] |=> tx_count == '0)
    else $error("transmit FIFO not flushed");
  AST_SHADOW: assert property (s_fcr_wr |=> q.shadow == ($past(bus.wdata) & FCR_SELFCLR))
    else $error("shadow copy mismatch");
  AST_TX_LOAD_IDLE: assert property (tx_pop |-> q.tx_st == TX_IDLE ##1 q.tx_st == TX_START && !txd)
    else $error("shifter loaded while busy");
  AST_TX_LSB_FIRST: assert property (s_tx_begin |-> txd == $past(q.tx_sh[0]) || q.lcr[LCR_BRK])
    else $error("first data bit not lsb");
  AST_THRE_CLEAR: assert property (tx_push |=> !q.thre_int || tx_empty)
    else $error("empty flag survived a write");
  AST_RDA_GATE: assert property (!q.interrupt_enable[0] |-> iir_code != IIR_RDA && iir_code != IIR_TOUT)
    else $error("data interrupt without enable");
  AST_LINE_PRIO: assert property (q.interrupt_enable[2] && q.err != 4'h0 |-> iir_code == IIR_LINE)
    else $error("line status not top priority");
  AST_MODEM_GATE: assert property (iir_code == IIR_MODEM |-> q.interrupt_enable[3] && q.msr_delta != 4'h0)
    else $error("modem interrupt without cause");
  AST_TRIG_14: assert property (q.fifo_en && q.trig == 2'h3 && int'(rx_count) < TRIG_L3 |-> iir_code != IIR_RDA)
    else $error("data interrupt below trigger");
  AST_RX_PUSH: assert property (q.rx_st == RX_STOP && q.tick && q.rx_cnt == BIT_LAST |=> q.rx_push)
    else $error("completed character not moved");
endmodule

/* dv/ufr_remote.sv */
// Remote serial device on the far side of the port: 8N1 at 460.8k baud.
// Assumes the port runs divisor 1 with 8-bit words, no parity, one stop bit.
`timescale 1ns/1ps

module ufr_remote #(
  parameter real BIT_NS = 2170.14
) (
  input wire logic txd,
  output logic rxd
);
  logic [7:0] got [0:7];
  logic [7:0] sh;
  int n_got;

  // ==========================================================================
  // Sender, start low then data least significant bit first
  task automatic send(input logic [7:0] b);
    rxd = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      #(BIT_NS);
    end
    rxd = 1'b1;
    #(BIT_NS);
  endtask

  // ==========================================================================
  // Receiver, samples at mid-bit
  initial begin
    rxd = 1'b1;
    n_got = 0;
    forever begin
      @(negedge txd);
      #(BIT_NS / 2);
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        sh[i] = txd;
      end
      #(BIT_NS);
      got[n_got % 8] = sh;
      n_got++;
    end
  end
endmodule

/* dv/tb_ufr_core.sv */
// Self-checking bench of the serial port core with a remote serial device.
// Assumes ufr_pkg compiled first; clock 100 MHz, bus driven 1 ns after edges.
`timescale 1ns/1ps

module tb_ufr_core import ufr_pkg::*;;
  logic mclk;
  logic reset;
  logic ce;
  ufr_bus_req_s bus;
  logic [7:0] rdata;
  logic [7:0] shadow;
  logic [7:0] d;
  logic rxd;
  logic txd;
  logic [3:0] mctl_n;
  logic [3:0] modem_n;
  logic irq;
  int n_fail;
  int compares;

  ufr_core u_ufr_core (.mclk(mclk), .reset(reset), .ce(ce), .bus(bus), .rdata(rdata), .rxd(rxd),
    .modem_in_n(modem_n), .txd(txd), .dtr_n(mctl_n[0]), .rts_n(mctl_n[1]), .aux_out_n(mctl_n[2]),
    .gate_out_n(mctl_n[3]),
    .irq(irq), .fifo_control_shadow(shadow));
  ufr_remote u_ufr_remote (.txd(txd), .rxd(rxd));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1;
    bus = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    #1;
    bus.wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk);
    #1;
    bus = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    #1;
    bus.rd = 1'b0;
    v = rdata;
  endtask

  // Flag settles a few cycles after the write that causes it
  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge mclk);
    #1;
    chk("irq", {7'h00, exp}, {7'h00, irq});
  endtask

  task automatic wait_rx(input int n);
    int k;
    for (k = 0; k < 8000 && u_ufr_remote.n_got < n; k++) @(posedge mclk);
    if (u_ufr_remote.n_got < n) begin
      n_fail++;
      $display("unexpected serial count expected %0d seen %0d", n, u_ufr_remote.n_got);
      print_verdict();
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    chk("shadow", 8'h00, shadow);
    reg_rd(OFS_IER, d);
    chk("enable", 8'h00, d);
    reg_wr(OFS_IER, 8'hFF);
    reg_rd(OFS_IER, d);
    chk("enable", 8'h0F, d);
    reg_wr(OFS_LCR, 8'h80);
    reg_wr(OFS_DATA, 8'h01);
    reg_wr(OFS_IER, 8'h00);
    reg_rd(OFS_DATA, d);
    chk("div low", 8'h01, d);
    reg_wr(OFS_LCR, 8'h03);
    reg_rd(OFS_IER, d);
    chk("enable", 8'h0F, d);
    reg_wr(OFS_IER, 8'h00);
  endtask

  task automatic t_gate();
    reg_rd(OFS_LSR, d);
    reg_rd(OFS_MSR, d);
    reg_wr(OFS_IER, 8'h02);
    chk_irq(1'b0);
    reg_wr(OFS_MCR, 8'h08);
    chk_irq(1'b1);
    chk("modem out", 8'h07, {4'h0, mctl_n});
    reg_wr(OFS_IER, 8'h00);
    chk_irq(1'b0);
    reg_wr(OFS_IER, 8'h02);
    chk_irq(1'b1);
    reg_rd(OFS_IIR, d);
    chk("ident", 8'h02, d);
    chk_irq(1'b0);
    reg_wr(OFS_IER, 8'h00);
  endtask

  task automatic t_tx();
    reg_wr(OFS_DATA, 8'hA5);
    wait_rx(1);
    chk("tx0", 8'hA5, u_ufr_remote.got[0]);
    reg_wr(OFS_DATA, 8'h3C);
    // Holding keeps one word outside FIFO mode, a write while holding and shifter are both busy would be dropped
    wait_rx(2);
    reg_wr(OFS_DATA, 8'hC3);
    wait_rx(3);
    chk("tx1", 8'h3C, u_ufr_remote.got[1]);
    chk("tx2", 8'hC3, u_ufr_remote.got[2]);
  endtask

  task automatic t_rx();
    u_ufr_remote.send(8'h96);
    repeat (300) @(posedge mclk);
    reg_rd(OFS_LSR, d);
    chk("ready", 8'h01, {7'h00, d[0]});
    reg_rd(OFS_DATA, d);
    chk("rx", 8'h96, d);
    reg_wr(OFS_IER, 8'h04);
    u_ufr_remote.send(8'h5A);
    u_ufr_remote.send(8'h69);
    chk_irq(1'b1);
    reg_rd(OFS_IIR, d);
    chk("ident", 8'h06, d);
    reg_rd(OFS_LSR, d);
    chk("status", 8'h63, d);
    chk_irq(1'b0);
    reg_rd(OFS_DATA, d);
    chk("rx", 8'h5A, d);
    reg_wr(OFS_IER, 8'h00);
  endtask

  task automatic t_modem();
    reg_rd(OFS_MSR, d);
    reg_wr(OFS_IER, 8'h08);
    chk_irq(1'b0);
    @(posedge mclk);
    #1;
    modem_n = 4'hE;
    chk_irq(1'b1);
    reg_rd(OFS_MSR, d);
    chk("modem", 8'h11, d);
    chk_irq(1'b0);
    reg_wr(OFS_IER, 8'h00);
  endtask

  task automatic t_fifo();
    reg_wr(OFS_IIR, 8'hC7);
    chk("shadow", 8'hC1, shadow);
    reg_rd(OFS_IIR, d);
    chk("ident", 8'hC1, d);
    u_ufr_remote.send(8'h11);
    u_ufr_remote.send(8'h22);
    repeat (300) @(posedge mclk);
    reg_wr(OFS_IIR, 8'h03);
    reg_rd(OFS_LSR, d);
    chk("ready", 8'h00, {7'h00, d[0]});
    reg_wr(OFS_IIR, 8'h0D);
    chk("shadow", 8'h09, shadow);
    reg_wr(OFS_IIR, 8'h00);
    reg_rd(OFS_IIR, d);
    chk("ident", 8'h01, d);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    n_fail = 0;
    compares = 0;
    reset = 1'b1;
    ce = 1'b1;
    bus = '0;
    modem_n = 4'hF;
    repeat (12) @(posedge mclk);
    #1;
    reset = 1'b0;
    chk("irq", 8'h00, {7'h00, irq});
    t_regs();
    t_gate();
    t_tx();
    t_rx();
    t_modem();
    t_fifo();
    print_verdict();
  end
endmodule
